// file: inc/dtc_pkg.sv
package dtc_pkg;

  // Register map, byte registers on the strobed port
  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_ZERO_LOW = 8'h8a;
  localparam logic [7:0] DTC_ADDR_ONE_LOW = 8'h8b;
  localparam logic [7:0] DTC_ADDR_ZERO_HIGH = 8'h8c;
  localparam logic [7:0] DTC_ADDR_ONE_HIGH = 8'h8d;
  localparam logic [7:0] DTC_ADDR_DIV = 8'h8e;
  localparam logic [7:0] DTC_ADDR_IRQ_EN = 8'ha8;
  localparam logic [7:0] DTC_ADDR_IRQ_PRI = 8'hb8;

  localparam logic [7:0] DTC_RESET_BYTE = 8'h00;

  // Control and flag register fields
  localparam int DTC_CTRL_ZERO_RUN = 4;
  localparam int DTC_CTRL_ZERO_FLAG = 5;
  localparam int DTC_CTRL_ONE_RUN = 6;
  localparam int DTC_CTRL_ONE_FLAG = 7;
  localparam int DTC_CTRL_EXT_MSB = 3;

  // Mode register: one nibble per timer
  localparam int DTC_MODE_ONE_LSB = 4;
  localparam int DTC_MODE_ZERO_LSB = 0;
  localparam int DTC_NIBBLE = 4;

  // Clock divider control
  localparam int DTC_DIV_ZERO_SEL = 3;
  localparam int DTC_DIV_ONE_SEL = 4;
  localparam logic [7:0] DTC_DIV_MASK = 8'h1f;

  // Interrupt enable and priority fields
  localparam int DTC_IRQ_GLOBAL = 7;
  localparam int DTC_IRQ_ONE = 3;
  localparam int DTC_IRQ_ZERO = 1;
  localparam logic [7:0] DTC_PRI_MASK = 8'h3f;

  localparam logic [7:0] DTC_VEC_ZERO = 8'h0b;
  localparam logic [7:0] DTC_VEC_ONE = 8'h1b;
  localparam logic [7:0] DTC_VEC_NONE = 8'h00;

  // Internal clock division
  localparam int DTC_DIV_SLOW = 12;
  localparam int DTC_DIV_FAST = 4;
  localparam logic [3:0] DTC_DIV_LAST = 4'(DTC_DIV_SLOW - 1);
  localparam logic [1:0] DTC_FAST_LAST = 2'(DTC_DIV_FAST - 1);

  localparam logic [4:0] DTC_PRESCALE_LAST = 5'h1f;
  localparam logic [7:0] DTC_BYTE_LAST = 8'hff;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic gate;
    logic src_sel;
    dtc_mode_t mode;
  } dtc_tmode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_count_t;

  typedef struct packed {
    dtc_count_t count;
    logic ovf;
  } dtc_step_t;

endpackage

// file: core/dtc_timers.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Internal timing counts system clock divided by 4 or by 12 per divider bit.
// - Counter mode samples count pin each clock, counts each falling transition.
// - Mode 0 feeds high byte through divide-by-32 prescaler in low five bits.
// - Mode 0 count is 13 bits; upper three low-byte bits are ignored.
// - Mode 1 cascades high and low byte into one 16-bit counter.
// - Mode 2 low byte overflow sets flag, reloads from unchanged high byte.
// - Mode 3 splits timer zero: low under own controls, high under timer one run.
// - Timer one in mode 3 holds its count.
// - With gate set, counting needs run bit and high gate pin; else run alone.
// - Count source bit picks external count pin or internal divided clock.
// - Mode register: timer one nibble in bits 7..4, timer zero in 3..0.
// - Control register: run zero bit 4, flag zero 5, run one 6, flag one 7.
// - Rollover to zero sets overflow flag; vectoring to the routine clears it.
// - Timer zero requests vector 0x0B priority 2; timer one 0x1B priority 4.
// - Software flag writes raise or cancel requests like hardware changes.
// - Request needs global enable and own enable, bit 1 zero, bit 3 one.
// - Priority bit set puts the timer interrupt in the high group.
// - Timer zero mode 3 high byte overflow sets timer one overflow flag.
module dtc_timers
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic timer_zero_gate_pin,
  input wire logic timer_one_gate_pin,
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one,
  output logic irq_zero_req,
  output logic irq_one_req,
  output logic irq_zero_high,
  output logic irq_one_high,
  output logic irq_valid,
  output logic [7:0] irq_vector
);

  // One counting step of a timer for a given mode
  function automatic dtc_pkg::dtc_step_t dtc_step
  (
    input dtc_pkg::dtc_mode_t mode,
    input dtc_pkg::dtc_count_t cur
  );
    dtc_pkg::dtc_step_t r;
    logic [16:0] sum;
    r.count = cur;
    r.ovf = 1'b0;
    sum = {1'b0, cur} + 17'h0_0001;
    case (mode)
      dtc_pkg::DTC_MODE_13BIT:
      begin
        // Upper low-byte bits are left alone and play no part
        r.count.low[4:0] = cur.low[4:0] + 5'h01;
        if (cur.low[4:0] == dtc_pkg::DTC_PRESCALE_LAST)
        begin
          r.count.high = cur.high + 8'h01;
          r.ovf = (cur.high == dtc_pkg::DTC_BYTE_LAST);
        end
      end
      dtc_pkg::DTC_MODE_16BIT:
      begin
        r.count = sum[15:0];
        r.ovf = sum[16];
      end
      dtc_pkg::DTC_MODE_RELOAD:
      begin
        if (cur.low == dtc_pkg::DTC_BYTE_LAST)
        begin
          r.count.low = cur.high;
          r.ovf = 1'b1;
        end
        else
        begin
          r.count.low = cur.low + 8'h01;
        end
      end
      default:
      begin
        // Split mode: the low byte alone, high byte handled elsewhere
        r.count.low = cur.low + 8'h01;
        r.ovf = (cur.low == dtc_pkg::DTC_BYTE_LAST);
      end
    endcase
    return r;
  endfunction

  // Count tick for one timer from its source and divider choice
  function automatic logic dtc_tick
  (
    input logic src_sel,
    input logic fast_sel,
    input logic fast_tick,
    input logic slow_tick,
    input logic pin_fall
  );
    logic internal_tick;
    internal_tick = fast_sel ? fast_tick : slow_tick;
    return src_sel ? pin_fall : internal_tick;
  endfunction

  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] div_sel_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] irq_pri_reg;
  dtc_pkg::dtc_count_t cnt_zero_reg;
  dtc_pkg::dtc_count_t cnt_one_reg;
  logic [3:0] div_cnt_reg;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [1:0] count_prev_reg;
  logic [7:0] rdata_reg;
  logic irq_valid_reg;
  logic [7:0] irq_vector_reg;

  dtc_pkg::dtc_tmode_t tmode_zero;
  dtc_pkg::dtc_tmode_t tmode_one;
  dtc_pkg::dtc_step_t step_zero;
  dtc_pkg::dtc_step_t step_one;
  logic slow_tick;
  logic fast_tick;
  logic fall_zero;
  logic fall_one;
  logic gate_zero;
  logic gate_one;
  logic run_zero;
  logic run_one;
  logic en_zero;
  logic en_one;
  logic split_zero;
  logic inc_zero;
  logic inc_one;
  logic inc_split_high;
  logic ovf_zero;
  logic ovf_one;
  logic wr_ctrl;
  logic flag_zero_next;
  logic flag_one_next;
  logic [7:0] rd_val;
  logic [7:0] vector_next;

  assign wr_ctrl = wr && (addr == dtc_pkg::DTC_ADDR_CTRL);

  assign tmode_zero = mode_reg[dtc_pkg::DTC_MODE_ZERO_LSB +: dtc_pkg::DTC_NIBBLE];
  assign tmode_one = mode_reg[dtc_pkg::DTC_MODE_ONE_LSB +: dtc_pkg::DTC_NIBBLE];
  assign run_zero = ctrl_reg[dtc_pkg::DTC_CTRL_ZERO_RUN];
  assign run_one = ctrl_reg[dtc_pkg::DTC_CTRL_ONE_RUN];
  assign split_zero = (tmode_zero.mode == dtc_pkg::DTC_MODE_SPLIT);

  // Pins are asynchronous; two flops before anything looks at them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end
    else
    begin
      pin_meta_reg <= {timer_one_gate_pin, timer_zero_gate_pin,
                       timer_one_count_pin, timer_zero_count_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Previous synchronised level of the count pins for edge detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_prev_reg <= 2'h0;
    end
    else
    begin
      count_prev_reg <= pin_sync_reg[1:0];
    end
  end

  assign fall_zero = count_prev_reg[0] && !pin_sync_reg[0];
  assign fall_one = count_prev_reg[1] && !pin_sync_reg[1];
  assign gate_zero = pin_sync_reg[2];
  assign gate_one = pin_sync_reg[3];

  // Shared divider; the fast tick lands every fourth clock because 4 divides 12
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt_reg <= 4'h0;
    end
    else if (div_cnt_reg == dtc_pkg::DTC_DIV_LAST)
    begin
      div_cnt_reg <= 4'h0;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  assign slow_tick = (div_cnt_reg == dtc_pkg::DTC_DIV_LAST);
  assign fast_tick = (div_cnt_reg[1:0] == dtc_pkg::DTC_FAST_LAST);

  assign en_zero = run_zero && (!tmode_zero.gate || gate_zero);
  assign en_one = run_one && (!tmode_one.gate || gate_one);

  always_comb
  begin
    step_zero = dtc_step(tmode_zero.mode, cnt_zero_reg);
    step_one = dtc_step(tmode_one.mode, cnt_one_reg);
    inc_zero = en_zero && dtc_tick(tmode_zero.src_sel, div_sel_reg[dtc_pkg::DTC_DIV_ZERO_SEL],
                                   fast_tick, slow_tick, fall_zero);
    // Split high byte is always a timer, clocked internally, run by timer one
    inc_split_high = split_zero && run_one && dtc_tick(1'b0,
                     div_sel_reg[dtc_pkg::DTC_DIV_ZERO_SEL], fast_tick, slow_tick,
                     1'b0);
    inc_one = en_one && (tmode_one.mode != dtc_pkg::DTC_MODE_SPLIT) &&
              dtc_tick(tmode_one.src_sel, div_sel_reg[dtc_pkg::DTC_DIV_ONE_SEL],
                       fast_tick, slow_tick, fall_one);
  end

  assign ovf_zero = inc_zero && step_zero.ovf;
  assign ovf_one = (inc_one && step_one.ovf) ||
                   (inc_split_high && (cnt_zero_reg.high == dtc_pkg::DTC_BYTE_LAST));

  // Timer zero count; a software write wins over a count in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_zero_reg <= '0;
    end
    else
    begin
      if (wr && (addr == dtc_pkg::DTC_ADDR_ZERO_LOW))
      begin
        cnt_zero_reg.low <= wdata;
      end
      else if (inc_zero)
      begin
        cnt_zero_reg.low <= step_zero.count.low;
      end
      if (wr && (addr == dtc_pkg::DTC_ADDR_ZERO_HIGH))
      begin
        cnt_zero_reg.high <= wdata;
      end
      else if (split_zero)
      begin
        if (inc_split_high)
        begin
          cnt_zero_reg.high <= cnt_zero_reg.high + 8'h01;
        end
      end
      else if (inc_zero)
      begin
        cnt_zero_reg.high <= step_zero.count.high;
      end
    end
  end

  // Timer one count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_one_reg <= '0;
    end
    else
    begin
      if (wr && (addr == dtc_pkg::DTC_ADDR_ONE_LOW))
      begin
        cnt_one_reg.low <= wdata;
      end
      else if (inc_one)
      begin
        cnt_one_reg.low <= step_one.count.low;
      end
      if (wr && (addr == dtc_pkg::DTC_ADDR_ONE_HIGH))
      begin
        cnt_one_reg.high <= wdata;
      end
      else if (inc_one)
      begin
        cnt_one_reg.high <= step_one.count.high;
      end
    end
  end

  // Overflow sets win over both software and vector clears
  always_comb
  begin
    flag_zero_next = ctrl_reg[dtc_pkg::DTC_CTRL_ZERO_FLAG];
    flag_one_next = ctrl_reg[dtc_pkg::DTC_CTRL_ONE_FLAG];
    if (irq_ack_zero)
    begin
      flag_zero_next = 1'b0;
    end
    if (irq_ack_one)
    begin
      flag_one_next = 1'b0;
    end
    if (wr_ctrl)
    begin
      flag_zero_next = wdata[dtc_pkg::DTC_CTRL_ZERO_FLAG];
      flag_one_next = wdata[dtc_pkg::DTC_CTRL_ONE_FLAG];
    end
    if (ovf_zero)
    begin
      flag_zero_next = 1'b1;
    end
    if (ovf_one)
    begin
      flag_one_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= dtc_pkg::DTC_RESET_BYTE;
    end
    else
    begin
      ctrl_reg[dtc_pkg::DTC_CTRL_ZERO_FLAG] <= flag_zero_next;
      ctrl_reg[dtc_pkg::DTC_CTRL_ONE_FLAG] <= flag_one_next;
      if (wr_ctrl)
      begin
        ctrl_reg[dtc_pkg::DTC_CTRL_ZERO_RUN] <= wdata[dtc_pkg::DTC_CTRL_ZERO_RUN];
        ctrl_reg[dtc_pkg::DTC_CTRL_ONE_RUN] <= wdata[dtc_pkg::DTC_CTRL_ONE_RUN];
        // Low nibble belongs to the external interrupt logic; held as plain storage
        ctrl_reg[dtc_pkg::DTC_CTRL_EXT_MSB:0] <= wdata[dtc_pkg::DTC_CTRL_EXT_MSB:0];
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg <= dtc_pkg::DTC_RESET_BYTE;
      div_sel_reg <= dtc_pkg::DTC_RESET_BYTE;
      irq_en_reg <= dtc_pkg::DTC_RESET_BYTE;
      irq_pri_reg <= dtc_pkg::DTC_RESET_BYTE;
    end
    else if (wr)
    begin
      case (addr)
        dtc_pkg::DTC_ADDR_MODE:
        begin
          mode_reg <= wdata;
        end
        dtc_pkg::DTC_ADDR_DIV:
        begin
          div_sel_reg <= wdata & dtc_pkg::DTC_DIV_MASK;
        end
        dtc_pkg::DTC_ADDR_IRQ_EN:
        begin
          irq_en_reg <= wdata;
        end
        dtc_pkg::DTC_ADDR_IRQ_PRI:
        begin
          irq_pri_reg <= wdata & dtc_pkg::DTC_PRI_MASK;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Requests follow the flags directly, so software flag writes act at once
  assign irq_zero_req = irq_en_reg[dtc_pkg::DTC_IRQ_GLOBAL] &&
                        irq_en_reg[dtc_pkg::DTC_IRQ_ZERO] &&
                        ctrl_reg[dtc_pkg::DTC_CTRL_ZERO_FLAG];
  assign irq_one_req = irq_en_reg[dtc_pkg::DTC_IRQ_GLOBAL] &&
                       irq_en_reg[dtc_pkg::DTC_IRQ_ONE] &&
                       ctrl_reg[dtc_pkg::DTC_CTRL_ONE_FLAG];
  assign irq_zero_high = irq_pri_reg[dtc_pkg::DTC_IRQ_ZERO];
  assign irq_one_high = irq_pri_reg[dtc_pkg::DTC_IRQ_ONE];

  // High group first; inside a group timer zero (natural 2) beats timer one (4)
  always_comb
  begin
    vector_next = dtc_pkg::DTC_VEC_NONE;
    if (irq_zero_req && (irq_zero_high || !(irq_one_req && irq_one_high)))
    begin
      vector_next = dtc_pkg::DTC_VEC_ZERO;
    end
    else if (irq_one_req)
    begin
      vector_next = dtc_pkg::DTC_VEC_ONE;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_valid_reg <= 1'b0;
      irq_vector_reg <= dtc_pkg::DTC_VEC_NONE;
    end
    else
    begin
      irq_valid_reg <= irq_zero_req || irq_one_req;
      irq_vector_reg <= vector_next;
    end
  end

  // Read decode; the three unused low-byte bits of mode 0 still read back as stored
  always_comb
  begin
    case (addr)
      dtc_pkg::DTC_ADDR_CTRL: rd_val = ctrl_reg;
      dtc_pkg::DTC_ADDR_MODE: rd_val = mode_reg;
      dtc_pkg::DTC_ADDR_ZERO_LOW: rd_val = cnt_zero_reg.low;
      dtc_pkg::DTC_ADDR_ONE_LOW: rd_val = cnt_one_reg.low;
      dtc_pkg::DTC_ADDR_ZERO_HIGH: rd_val = cnt_zero_reg.high;
      dtc_pkg::DTC_ADDR_ONE_HIGH: rd_val = cnt_one_reg.high;
      dtc_pkg::DTC_ADDR_DIV: rd_val = div_sel_reg;
      dtc_pkg::DTC_ADDR_IRQ_EN: rd_val = irq_en_reg;
      dtc_pkg::DTC_ADDR_IRQ_PRI: rd_val = irq_pri_reg;
      default: rd_val = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rd ? rd_val : 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign irq_valid = irq_valid_reg;
  assign irq_vector = irq_vector_reg;

endmodule

// file: bench/dtc_pins_model.sv
`timescale 1ns/1ps
module dtc_pins_model
(
  input wire logic clk,
  input wire logic [1:0] fall_req,
  input wire logic slow,
  input wire logic [1:0] gate_lvl,
  output logic timer_zero_count_pin,
  output logic timer_one_count_pin,
  output logic timer_zero_gate_pin,
  output logic timer_one_gate_pin
);
  logic [3:0] cnt0 = 4'h0;
  logic [3:0] cnt1 = 4'h0;
  // Low pulse held long enough for the two-flop pin sampler in either speed
  always @(posedge clk)
  begin
    cnt0 <= fall_req[0] ? (slow ? 4'h6 : 4'h2) : ((cnt0 != 4'h0) ? cnt0 - 4'h1 : 4'h0);
    cnt1 <= fall_req[1] ? (slow ? 4'h6 : 4'h2) : ((cnt1 != 4'h0) ? cnt1 - 4'h1 : 4'h0);
  end
  assign timer_zero_count_pin = (cnt0 == 4'h0);
  assign timer_one_count_pin = (cnt1 == 4'h0);
  assign timer_zero_gate_pin = gate_lvl[0];
  assign timer_one_gate_pin = gate_lvl[1];
endmodule

// file: bench/dtc_timers_asserts.sv
`timescale 1ns/1ps
module dtc_timers_asserts
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic timer_zero_gate_pin,
  input wire logic timer_one_gate_pin,
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one,
  input wire logic irq_zero_req,
  input wire logic irq_one_req,
  input wire logic irq_zero_high,
  input wire logic irq_one_high,
  input wire logic irq_valid,
  input wire logic [7:0] irq_vector
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_en0;
    wr && addr == dtc_pkg::DTC_ADDR_IRQ_EN && wdata[7] && wdata[1];
  endsequence
  sequence s_set0;
    wr && addr == dtc_pkg::DTC_ADDR_CTRL && wdata[5];
  endsequence
  sequence s_wmode;
    wr && addr == dtc_pkg::DTC_ADDR_MODE;
  endsequence
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_MODE_READ: assert property (s_wmode ##2 (rd && addr == dtc_pkg::DTC_ADDR_MODE) |=> rdata == $past(wdata, 3))
    else $error("mode register readback differs");
  AST_IRQ_VALID: assert property (1'b1 |=> irq_valid == $past(irq_zero_req || irq_one_req))
    else $error("interrupt valid does not follow requests");
  AST_VEC_ZERO: assert property (irq_zero_req && (irq_zero_high || !irq_one_req || !irq_one_high) |=> irq_vector == 8'h0b)
    else $error("timer zero vector wrong");
  AST_VEC_ONE: assert property (irq_one_req && (!irq_zero_req || (irq_one_high && !irq_zero_high)) |=> irq_vector == 8'h1b)
    else $error("timer one vector wrong");
  AST_VEC_NONE: assert property (!irq_zero_req && !irq_one_req |=> irq_vector == 8'h00)
    else $error("vector without request");
  AST_ACK_CLEAR: assert property (irq_ack_zero |=> !irq_zero_req)
    else $error("acknowledge did not clear timer zero request");
  AST_SW_SET: assert property (s_en0 ##2 s_set0 |=> irq_zero_req)
    else $error("software flag set raised no request");
  AST_EN_OFF: assert property (wr && addr == dtc_pkg::DTC_ADDR_IRQ_EN && !wdata[7] |=> !irq_zero_req && !irq_one_req)
    else $error("request with global enable off");
  AST_PRI: assert property (wr && addr == dtc_pkg::DTC_ADDR_IRQ_PRI |=> irq_zero_high == $past(wdata[1]) && irq_one_high == $past(wdata[3]))
    else $error("priority outputs differ from written bits");
endmodule
bind dtc_timers dtc_timers_asserts dtc_timers_asserts_inst (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .timer_zero_count_pin(timer_zero_count_pin), .timer_one_count_pin(timer_one_count_pin),
  .timer_zero_gate_pin(timer_zero_gate_pin), .timer_one_gate_pin(timer_one_gate_pin),
  .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one), .irq_zero_req(irq_zero_req),
  .irq_one_req(irq_one_req), .irq_zero_high(irq_zero_high), .irq_one_high(irq_one_high),
  .irq_valid(irq_valid), .irq_vector(irq_vector));

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_ack_zero = 1'b0;
  logic irq_ack_one = 1'b0;
  logic [1:0] fall_req = 2'b00;
  logic slow = 1'b0;
  logic [1:0] gate_lvl = 2'b00;
  logic [1:0] seen = 2'b00;
  logic seen_clr = 1'b0;
  wire logic p_c0, p_c1, p_g0, p_g1;
  logic [7:0] rdata, irq_vector, v, rv;
  logic irq_zero_req, irq_one_req, irq_zero_high, irq_one_high, irq_valid;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 3021;
  int cs [11][8] = '{'{0,0,8'hfe,8'hff,2,1,0,0}, '{0,0,8'h1f,8'h05,1,1,0,0},
    '{0,1,8'hf0,8'hff,16,1,0,0}, '{1,2,8'hfd,8'h40,5,1,0,0}, '{1,3,8'h10,8'h20,4,1,0,0},
    '{0,3,8'hfe,8'h00,3,1,0,0}, '{2,3,8'h00,8'hfe,3,1,0,0}, '{0,1,0,0,4,0,0,0},
    '{1,1,0,0,12,0,0,0}, '{0,1,0,0,12,1,8'h08,0}, '{1,1,0,0,12,1,8'h80,1}};
  logic [7:0] ra [4] = '{dtc_pkg::DTC_ADDR_MODE, dtc_pkg::DTC_ADDR_DIV,
    dtc_pkg::DTC_ADDR_IRQ_PRI, dtc_pkg::DTC_ADDR_ONE_HIGH};
  logic [7:0] rm [4] = '{8'hff, 8'h1f, 8'h3f, 8'hff};
  logic [7:0] pv [4] = '{8'h00, 8'h08, 8'h02, 8'h0a};
  logic [7:0] ev [4] = '{8'h0b, 8'h1b, 8'h0b, 8'h0b};

  dtc_timers dtc_timers_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer_zero_count_pin(p_c0), .timer_one_count_pin(p_c1),
    .timer_zero_gate_pin(p_g0), .timer_one_gate_pin(p_g1), .irq_ack_zero(irq_ack_zero),
    .irq_ack_one(irq_ack_one), .irq_zero_req(irq_zero_req), .irq_one_req(irq_one_req),
    .irq_zero_high(irq_zero_high), .irq_one_high(irq_one_high), .irq_valid(irq_valid),
    .irq_vector(irq_vector));
  dtc_pins_model dtc_pins_model_inst (.clk(clk), .fall_req(fall_req), .slow(slow),
    .gate_lvl(gate_lvl), .timer_zero_count_pin(p_c0), .timer_one_count_pin(p_c1),
    .timer_zero_gate_pin(p_g0), .timer_one_gate_pin(p_g1));

  always #2.5 clk = ~clk;
  // One process owns seen, so a clear cannot race the accumulate
  always @(posedge clk)
    seen <= seen_clr ? 2'b00 : (seen | {irq_one_req, irq_zero_req});
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Step off the edge so callers see the registers after the write
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic ack(input logic [1:0] w);
    @(posedge clk);
    irq_ack_zero <= w[0];
    irq_ack_one <= w[1];
    @(posedge clk);
    irq_ack_zero <= 1'b0;
    irq_ack_one <= 1'b0;
  endtask

  // Integer model of one timer; t 2 stands for the split high byte of timer zero
  function automatic void model(input int t, input int m, input int n, inout int lo,
    inout int hi, output int ovf);
    ovf = 0;
    for (int i = 0; i < n; i++)
    begin
      if (t == 2)
      begin
        hi = (hi + 1) % 256;
        ovf |= (hi == 0);
      end
      else if (m == 0)
      begin
        lo = lo - lo % 32 + (lo % 32 + 1) % 32;
        if (lo % 32 == 0)
        begin
          hi = (hi + 1) % 256;
          ovf |= (hi == 0);
        end
      end
      else if (m == 1 || (m == 3 && t == 0))
      begin
        lo = (lo + 1) % 256;
        if (lo == 0 && m == 1)
          hi = (hi + 1) % 256;
        ovf |= (lo == 0 && (m == 3 || hi == 0));
      end
      else if (m == 2)
      begin
        lo = lo + 1;
        if (lo == 256)
        begin
          lo = hi;
          ovf = 1;
        end
      end
    end
  endfunction

  task automatic run_case(input int c[8]);
    int lo, hi, ovf, k;
    logic [7:0] la, ha;
    lo = c[2];
    hi = c[3];
    k = c[5] ? 4 : 12;
    la = (c[0] == 1) ? dtc_pkg::DTC_ADDR_ONE_LOW : dtc_pkg::DTC_ADDR_ZERO_LOW;
    ha = (c[0] == 1) ? dtc_pkg::DTC_ADDR_ONE_HIGH : dtc_pkg::DTC_ADDR_ZERO_HIGH;
    model(c[0], c[1], (c[6] != 0 && c[7] == 0) ? 0 : c[4], lo, hi, ovf);
    gate_lvl <= {c[7] != 0, c[7] != 0};
    wr_reg(dtc_pkg::DTC_ADDR_MODE, 8'(c[1] * 17 + c[6]));
    wr_reg(dtc_pkg::DTC_ADDR_DIV, c[5] ? ((c[0] == 1) ? 8'h10 : 8'h08) : 8'h00);
    wr_reg(la, 8'(c[2]));
    wr_reg(ha, 8'(c[3]));
    seen_clr <= 1'b1;
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, (c[0] == 0) ? 8'h10 : 8'h40);
    seen_clr <= 1'b0;
    repeat (k * c[4] - 2) @(posedge clk);
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h00);
    rd_reg(la, v);
    chk("low byte", 8'(lo), v);
    rd_reg(ha, v);
    chk("high byte", 8'(hi), v);
    chk("overflow seen", 8'(ovf), 8'(seen[c[0] != 0]));
    ack(2'b11);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i])
    begin
      rd_reg(ra[i], v);
      chk("reset value", 8'h00, v);
    end
    for (int i = 0; i < 12; i++)
    begin
      rv = 8'($random(seed));
      wr_reg(ra[i % 4], rv);
      rd_reg(ra[i % 4], v);
      chk("register readback", rv & rm[i % 4], v);
    end
    wr_reg(8'h90, 8'h5a);
    rd_reg(8'h90, v);
    chk("unmapped read", 8'h00, v);
    wr_reg(dtc_pkg::DTC_ADDR_IRQ_EN, 8'h8a);
    foreach (cs[i])
      run_case(cs[i]);
    for (int t = 0; t < 2; t++)
    begin
      slow <= t[0];
      wr_reg(dtc_pkg::DTC_ADDR_MODE, 8'h55);
      wr_reg(t ? dtc_pkg::DTC_ADDR_ONE_LOW : dtc_pkg::DTC_ADDR_ZERO_LOW, 8'h00);
      wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h50);
      repeat (5)
      begin
        @(posedge clk);
        fall_req <= t ? 2'b10 : 2'b01;
        @(posedge clk);
        fall_req <= 2'b00;
        repeat (16) @(posedge clk);
      end
      wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h00);
      rd_reg(t ? dtc_pkg::DTC_ADDR_ONE_LOW : dtc_pkg::DTC_ADDR_ZERO_LOW, v);
      chk("pin events", 8'h05, v);
    end
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'ha0);
    rd_reg(dtc_pkg::DTC_ADDR_CTRL, v);
    chk("flags", 8'ha0, v);
    foreach (pv[i])
    begin
      wr_reg(dtc_pkg::DTC_ADDR_IRQ_PRI, pv[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("vector", ev[i], irq_vector);
    end
    ack(2'b01);
    @(posedge clk);
    #1;
    chk("vector after ack", 8'h1b, irq_vector);
    ack(2'b10);
    @(posedge clk);
    #1;
    chk("vector idle", 8'h00, irq_vector);
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h20);
    chk("sw request", 8'h01, 8'(irq_zero_req));
    wr_reg(dtc_pkg::DTC_ADDR_IRQ_EN, 8'h0a);
    chk("masked request", 8'h00, 8'(irq_zero_req));
    wr_reg(dtc_pkg::DTC_ADDR_IRQ_EN, 8'h82);
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h20);
    wr_reg(dtc_pkg::DTC_ADDR_CTRL, 8'h00);
    chk("cancelled request", 8'h00, 8'(irq_zero_req));
    final_report();
  end
endmodule
